// File: include/tdm_pkg.sv
// ============================================================================
// Function
// - channel B gain adjust, 8 bits, loaded from factory store at reset, RW.
// - reference adjust in bits 3:0, bits 7:4 reserved; factory loaded, RW.
// - channel A termination adjust, 8 bits, factory loaded, readable and writable.
// - channel B termination adjust, 8 bits, factory loaded, readable and writable.
// - bit 2 steers dither rounding error: 0 noise ratio, 1 offset and spurs.
// - bit 1 picks dither amplitude; 0 small (reset), 1 large.
// - bit 0 enables dither injection; resets to 1.
// - marker enable bit 0 puts timestamp on every output sample LSB.
// - marker path delayed to match sample latency through the device.
// - marked sample carries marker in LSB plus upper seven data bits.
// - lane alignment config always reports zero control bits per sample.
package tdm_pkg;
  // ==========================================================================
  // register map (printed offsets are indices; byte address is index times 4)
  localparam logic [8:0] IDX_GAIN_B = 9'h07B;
  localparam logic [8:0] IDX_REF_ADJ = 9'h07C;
  localparam logic [8:0] IDX_TERM_A = 9'h07E;
  localparam logic [8:0] IDX_TERM_B = 9'h07F;
  localparam logic [8:0] IDX_NOISE_CTL = 9'h09D;
  localparam logic [8:0] IDX_LSB_CTL = 9'h160;
  localparam int ADDR_W = 12;
  localparam int REG_W = 8;
  localparam int NUM_REGS = 6;
  // ==========================================================================
  // field positions and reset values
  localparam int REF_ADJ_LSB = 0;
  localparam int REF_ADJ_W = 4;
  localparam int NOISE_ERR_BIT = 2;
  localparam int NOISE_AMP_BIT = 1;
  localparam int NOISE_ON_BIT = 0;
  localparam int MARKER_ON_BIT = 0;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_NOISE_CTL = 8'h01;
  localparam logic [7:0] RST_LSB_CTL = 8'h00;
  localparam logic [7:0] ILA_CTRL_BITS = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [7:0] gain_b;
    logic [7:0] ref_adj;
    logic [7:0] term_a;
    logic [7:0] term_b;
  } tdm_trim_s;
  typedef struct packed {
    logic rounding_error_select;
    logic noise_level_select;
    logic noise_injection_on;
  } tdm_noise_s;
  typedef logic [REG_W-1:0] tdm_reg_t;
endpackage

// File: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tdm_pkg::*;
  localparam int LAT = 4;
  logic i_core_clk, i_rst, i_fuse_valid, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic i_timestamp, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_marker_on;
  tdm_trim_s i_fuse_trim, o_trim;
  tdm_noise_s o_noise;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp;
  logic [7:0] i_sample, o_sample, o_ila_ctrl_bits;
  logic [7:0] cnt = 8'h00;
  logic [7:0] hs [8];
  logic ht [8];
  int err_count = 0;
  int checks = 0;

  tdm_regs #(.MARKER_LAT(LAT)) i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_fuse_trim(i_fuse_trim), .i_fuse_valid(i_fuse_valid), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_sample(i_sample), .i_timestamp(i_timestamp), .o_sample(o_sample), .o_trim(o_trim),
    .o_noise(o_noise), .o_marker_on(o_marker_on), .o_ila_ctrl_bits(o_ila_ctrl_bits));

  // ==========================================================================
  // clock, sample stream and history of sampled inputs
  initial begin
    i_core_clk = 0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cnt <= cnt + 8'h01;
    i_sample <= cnt * 8'h25 + 8'h0B;
    i_timestamp <= cnt[1] ^ cnt[3] ^ cnt[4];
    for (int k = 7; k > 0; k--) begin
      hs[k] <= hs[k-1];
      ht[k] <= ht[k-1];
    end
    hs[0] <= i_sample;
    ht[0] <= i_timestamp;
  end

  // ==========================================================================
  // helpers
  function automatic logic [11:0] ba(input logic [8:0] idx);
    return {1'b0, idx, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    do begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready) i_awvalid <= 0;
      if (i_wvalid && o_wready) i_wvalid <= 0;
    end while (o_bvalid !== 1'b1);
    i_bready <= 0;
    chk(32'(o_bresp), 32'(er));
    @(posedge i_core_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do begin
      @(posedge i_core_clk);
      if (i_arvalid && o_arready) i_arvalid <= 0;
    end while (o_rvalid !== 1'b1);
    i_rready <= 0;
    chk(o_rdata, ed);
    chk(32'(o_rresp), 32'(er));
    @(posedge i_core_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_and_fuse();
    rd(ba(IDX_NOISE_CTL), 32'h01, RESP_OKAY);
    rd(ba(IDX_LSB_CTL), 32'h00, RESP_OKAY);
    chk(32'(o_noise), 32'h1);
    i_fuse_valid <= 1;
    repeat (3) @(posedge i_core_clk);
    rd(ba(IDX_GAIN_B), 32'hA5, RESP_OKAY);
    rd(ba(IDX_REF_ADJ), 32'h0C, RESP_OKAY);
    rd(ba(IDX_TERM_A), 32'h3C, RESP_OKAY);
    rd(ba(IDX_TERM_B), 32'hC3, RESP_OKAY);
    chk(32'(o_trim), 32'hA50C3CC3);
  endtask
  task automatic t_rw();
    logic [8:0] idx [6] = '{IDX_GAIN_B, IDX_REF_ADJ, IDX_TERM_A, IDX_TERM_B, IDX_NOISE_CTL,
      IDX_LSB_CTL};
    logic [7:0] val [6] = '{8'h5A, 8'hF3, 8'h81, 8'h7E, 8'hFE, 8'hF0};
    logic [7:0] nv [3] = '{8'h05, 8'h03, 8'h00};
    for (int k = 0; k < 6; k++) wr(ba(idx[k]), {24'hFFFFFF, val[k]}, RESP_OKAY);
    for (int k = 0; k < 6; k++) rd(ba(idx[k]), 32'(val[k]), RESP_OKAY);
    chk(32'(o_trim), 32'h5A03817E);
    chk(32'(o_noise), 32'h6);
    chk(32'(o_marker_on), 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ba(IDX_NOISE_CTL), 32'(nv[k]), RESP_OKAY);
      @(posedge i_core_clk);
      chk(32'(o_noise), 32'(nv[k][2:0]));
    end
    wr(12'h000, 32'h55, RESP_SLVERR);
    rd(12'h004, 32'h0, RESP_SLVERR);
    // byte lane 0 strobe off: the write must leave the register alone
    i_wstrb <= 4'hE;
    wr(ba(IDX_GAIN_B), 32'hFF, RESP_OKAY);
    i_wstrb <= 4'hF;
    rd(ba(IDX_GAIN_B), 32'h5A, RESP_OKAY);
  endtask
  task automatic t_marker(input logic on);
    wr(ba(IDX_LSB_CTL), 32'(on), RESP_OKAY);
    repeat (2) @(posedge i_core_clk);
    chk(32'(o_marker_on), 32'(on));
    repeat (20) begin
      @(negedge i_core_clk);
      chk(32'(o_ila_ctrl_bits), 32'h0);
      if (on) chk(32'(o_sample), 32'({hs[LAT][7:1], ht[LAT]}));
      else chk(32'(o_sample), 32'(hs[LAT]));
    end
    @(posedge i_core_clk);
  endtask
  // mid-run reset: controls back to reset values, factory trims reloaded
  task automatic t_reset_again();
    i_rst <= 1;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 0;
    @(posedge i_core_clk);
    rd(ba(IDX_NOISE_CTL), 32'h01, RESP_OKAY);
    rd(ba(IDX_LSB_CTL), 32'h00, RESP_OKAY);
    rd(ba(IDX_GAIN_B), 32'hA5, RESP_OKAY);
    rd(ba(IDX_TERM_A), 32'h3C, RESP_OKAY);
    chk(32'(o_trim), 32'hA50C3CC3);
  endtask

  // ==========================================================================
  // watchdog
  initial begin
    #200000;
    err_count++;
    end_sim();
  end

  // ==========================================================================
  // main sequence
  initial begin
    i_rst = 1;
    {i_fuse_valid, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_fuse_trim = 32'hA50C3CC3;
    i_awaddr = '0;
    i_araddr = '0;
    i_wdata = '0;
    i_wstrb = 4'hF;
    repeat (12) @(posedge i_core_clk);
    i_rst <= 0;
    @(posedge i_core_clk);
    t_reset_and_fuse();
    t_rw();
    t_marker(1'b1);
    t_marker(1'b0);
    t_reset_again();
    end_sim();
  end
endmodule // tb
`default_nettype wire

// File: verilog/tdm_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tdm_regs #(
  parameter int MARKER_LAT = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // factory trim store, valid after reset
  input wire tdm_pkg::tdm_trim_s i_fuse_trim,
  input wire logic i_fuse_valid,
  // axi4-lite slave
  input wire logic [tdm_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [tdm_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // sample path
  input wire logic [7:0] i_sample,
  input wire logic i_timestamp,
  output logic [7:0] o_sample,
  // controls toward analog and link
  output tdm_pkg::tdm_trim_s o_trim,
  output tdm_pkg::tdm_noise_s o_noise,
  output logic o_marker_on,
  output logic [7:0] o_ila_ctrl_bits
);
  import tdm_pkg::*;

  // ==========================================================================
  // address decode, every word index bit compared so no upper alias hits
  localparam int IDX_W = ADDR_W - 2;
  function automatic logic [2:0] dec_idx(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    unique case (idx)
      IDX_W'(IDX_GAIN_B): dec_idx = 3'h0;
      IDX_W'(IDX_REF_ADJ): dec_idx = 3'h1;
      IDX_W'(IDX_TERM_A): dec_idx = 3'h2;
      IDX_W'(IDX_TERM_B): dec_idx = 3'h3;
      IDX_W'(IDX_NOISE_CTL): dec_idx = 3'h4;
      IDX_W'(IDX_LSB_CTL): dec_idx = 3'h5;
      default: dec_idx = 3'h7;
    endcase
  endfunction

  // ==========================================================================
  // register storage and write channel
  tdm_reg_t regs_ff [NUM_REGS];
  tdm_reg_t nxt_regs [NUM_REGS];
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic aw_have_ff, nxt_aw_have;
  logic [7:0] wbyte_ff, nxt_wbyte;
  logic wstb_ff, nxt_wstb;
  logic w_have_ff, nxt_w_have;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic fuse_done_ff, nxt_fuse_done;
  logic [2:0] widx;

  assign o_awready = !aw_have_ff && !bvalid_ff;
  assign o_wready = !w_have_ff && !bvalid_ff;
  assign widx = dec_idx(awaddr_ff);

  // next state of storage, factory load and write response
  always_comb begin
    nxt_regs = regs_ff;
    nxt_awaddr = awaddr_ff;
    nxt_aw_have = aw_have_ff;
    nxt_wbyte = wbyte_ff;
    nxt_wstb = wstb_ff;
    nxt_w_have = w_have_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_fuse_done = fuse_done_ff;
    if (!fuse_done_ff && i_fuse_valid) begin
      nxt_regs[0] = i_fuse_trim.gain_b;
      nxt_regs[1] = i_fuse_trim.ref_adj;
      nxt_regs[2] = i_fuse_trim.term_a;
      nxt_regs[3] = i_fuse_trim.term_b;
      nxt_fuse_done = 1'b1;
    end
    if (i_awvalid && o_awready) begin
      nxt_awaddr = i_awaddr;
      nxt_aw_have = 1'b1;
    end
    if (i_wvalid && o_wready) begin
      nxt_wbyte = i_wdata[7:0];
      nxt_wstb = i_wstrb[0];
      nxt_w_have = 1'b1;
    end
    if (aw_have_ff && w_have_ff) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      if (widx == 3'h7) begin
        nxt_bresp = RESP_SLVERR;
      end else begin
        nxt_bresp = RESP_OKAY;
        // full byte stored, reserved bits included
        if (wstb_ff) begin
          nxt_regs[widx] = wbyte_ff;
        end
      end
    end
    if (bvalid_ff && i_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // register the write side
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      regs_ff[0] <= RST_TRIM;
      regs_ff[1] <= RST_TRIM;
      regs_ff[2] <= RST_TRIM;
      regs_ff[3] <= RST_TRIM;
      regs_ff[4] <= RST_NOISE_CTL;
      regs_ff[5] <= RST_LSB_CTL;
      awaddr_ff <= '0;
      aw_have_ff <= 1'b0;
      wbyte_ff <= 8'h00;
      wstb_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      fuse_done_ff <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
      awaddr_ff <= nxt_awaddr;
      aw_have_ff <= nxt_aw_have;
      wbyte_ff <= nxt_wbyte;
      wstb_ff <= nxt_wstb;
      w_have_ff <= nxt_w_have;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      fuse_done_ff <= nxt_fuse_done;
    end
  end

  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;

  // ==========================================================================
  // read channel
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [2:0] ridx;

  assign o_arready = !rvalid_ff;
  assign ridx = dec_idx(i_araddr);

  // read data captured on address acceptance
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (i_arvalid && o_arready) begin
      nxt_rvalid = 1'b1;
      if (ridx == 3'h7) begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = RESP_SLVERR;
      end else begin
        nxt_rdata = {24'h00_0000, regs_ff[ridx]};
        nxt_rresp = RESP_OKAY;
      end
    end else if (rvalid_ff && i_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // register the read side
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;

  // ==========================================================================
  // live controls straight from storage, lane alignment bits from ILA_CTRL_BITS
  assign o_trim.gain_b = regs_ff[0];
  assign o_trim.ref_adj = {4'h0, regs_ff[1][REF_ADJ_LSB +: REF_ADJ_W]};
  assign o_trim.term_a = regs_ff[2];
  assign o_trim.term_b = regs_ff[3];
  assign o_noise.rounding_error_select = regs_ff[4][NOISE_ERR_BIT];
  assign o_noise.noise_level_select = regs_ff[4][NOISE_AMP_BIT];
  assign o_noise.noise_injection_on = regs_ff[4][NOISE_ON_BIT];
  assign o_marker_on = regs_ff[5][MARKER_ON_BIT];
  assign o_ila_ctrl_bits = ILA_CTRL_BITS;

  // ==========================================================================
  // marker and sample delay lines, equal total latency
  // the two sync flops count toward marker latency, so its line is two shorter
  localparam int TS_LAT = MARKER_LAT - 2; // MARKER_LAT must be at least 3
  logic ts_meta_ff, ts_sync_ff;
  logic [TS_LAT-1:0] ts_pipe_ff, nxt_ts_pipe;
  logic [7:0] smp_pipe_ff [MARKER_LAT];
  logic [7:0] nxt_smp_pipe [MARKER_LAT];
  logic [7:0] out_ff, nxt_out;

  // sample line and timestamp line both shift one stage per clock
  always_comb begin
    nxt_ts_pipe[0] = ts_sync_ff;
    for (int k = 1; k < TS_LAT; k++) begin
      nxt_ts_pipe[k] = ts_pipe_ff[k-1];
    end
    nxt_smp_pipe[0] = i_sample;
    for (int k = 1; k < MARKER_LAT; k++) begin
      nxt_smp_pipe[k] = smp_pipe_ff[k-1];
    end
    nxt_out = smp_pipe_ff[MARKER_LAT-1];
    if (o_marker_on) begin
      nxt_out = {smp_pipe_ff[MARKER_LAT-1][7:1], ts_pipe_ff[TS_LAT-1]};
    end
  end

  // timestamp pin passes two flip-flops, then the delay lines register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ts_meta_ff <= 1'b0;
      ts_sync_ff <= 1'b0;
      ts_pipe_ff <= '0;
      for (int k = 0; k < MARKER_LAT; k++) begin
        smp_pipe_ff[k] <= 8'h00;
      end
      out_ff <= 8'h00;
    end else begin
      ts_meta_ff <= i_timestamp;
      ts_sync_ff <= ts_meta_ff;
      ts_pipe_ff <= nxt_ts_pipe;
      smp_pipe_ff <= nxt_smp_pipe;
      out_ff <= nxt_out;
    end
  end

  assign o_sample = out_ff;

  // ==========================================================================
  // checks
  property p_marker_lsb;
    @(posedge i_core_clk) disable iff (i_rst)
      o_marker_on |=> o_sample[0] == $past(ts_pipe_ff[TS_LAT-1]);
  endproperty
  a_marker_lsb: assert property (p_marker_lsb) else $error("marker not on lsb");

  property p_upper_bits;
    @(posedge i_core_clk) disable iff (i_rst)
      o_marker_on |=> o_sample[7:1] == $past(smp_pipe_ff[MARKER_LAT-1][7:1]);
  endproperty
  a_upper_bits: assert property (p_upper_bits) else $error("data bits wrong");

  property p_no_marker;
    @(posedge i_core_clk) disable iff (i_rst)
      !o_marker_on |=> o_sample == $past(smp_pipe_ff[MARKER_LAT-1]);
  endproperty
  a_no_marker: assert property (p_no_marker) else $error("sample changed");

  property p_ila_zero;
    @(posedge i_core_clk) disable iff (i_rst) o_ila_ctrl_bits == 8'h00;
  endproperty
  a_ila_zero: assert property (p_ila_zero) else $error("ila bits nonzero");

  property p_dith_reset;
    @(posedge i_core_clk) $fell(i_rst) |-> o_noise.noise_injection_on
      && !o_noise.noise_level_select;
  endproperty
  a_dith_reset: assert property (p_dith_reset) else $error("dither reset wrong");

  property p_write_now;
    @(posedge i_core_clk) disable iff (i_rst)
      (aw_have_ff && w_have_ff && wstb_ff && widx == 3'h4)
      |=> o_noise.rounding_error_select == $past(wbyte_ff[2]);
  endproperty
  a_write_now: assert property (p_write_now) else $error("write late");

  property p_ref_mask;
    @(posedge i_core_clk) disable iff (i_rst) o_trim.ref_adj[7:4] == 4'h0;
  endproperty
  a_ref_mask: assert property (p_ref_mask) else $error("ref field width");

  property p_fuse_load;
    @(posedge i_core_clk) disable iff (i_rst)
      (!fuse_done_ff && i_fuse_valid && !(aw_have_ff && w_have_ff))
      |=> o_trim.gain_b == $past(i_fuse_trim.gain_b)
      && o_trim.term_a == $past(i_fuse_trim.term_a)
      && o_trim.term_b == $past(i_fuse_trim.term_b);
  endproperty
  a_fuse_load: assert property (p_fuse_load) else $error("fuse not loaded");

endmodule // tdm_regs
`default_nettype wire
